// file: hdl/bus_seq_params.svh
// Constants for the asynchronous bus cycle sequencer.
// Assumes one 100 MHz clock; each clk cycle is one half-clock bus state.
`ifndef BUS_SEQ_PARAMS_SVH
`define BUS_SEQ_PARAMS_SVH
`define BUS_ADDR_W 23
`define BUS_DATA_W 16
`define BUS_FC_W 3
`define BUS_FC_RESET 3'h0
`define BUS_ADDR_RESET 23'h000000
`define BUS_DATA_RESET 16'h0000
`endif

// file: hdl/bus_seq_pkg.sv
// Types for the asynchronous bus cycle sequencer.
// Assumes bus_seq_params.svh is on the include path.
`include "bus_seq_params.svh"
package bus_seq_pkg;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_S0 = 4'h1,
      ST_S1 = 4'h2,
      ST_S2 = 4'h3,
      ST_S3 = 4'h4,
      ST_S4 = 4'h5,
      ST_WAIT = 4'h6,
      ST_S5 = 4'h7,
      ST_S6 = 4'h8,
      ST_S7 = 4'h9,
      ST_E5 = 4'hA,
      ST_E6 = 4'hB,
      ST_E7 = 4'hC,
      ST_E8 = 4'hD,
      ST_E9 = 4'hE
   } bus_state_e;

   typedef struct packed {
      logic write;
      logic is_byte;
      logic [`BUS_FC_W-1:0] type_code;
      logic [`BUS_ADDR_W:0] byte_addr;
      logic [`BUS_DATA_W-1:0] wdata;
   } bus_req_s;

   typedef struct packed {
      logic fault;
      logic [`BUS_DATA_W-1:0] rdata;
   } bus_rsp_s;
endpackage

// file: hdl/bus_seq.sv
// Bus master sequencer: runs byte and word read/write cycles in states S0..S7.
// Assumes the core holds req stable while req_valid and req_ready meet;
// each clk cycle is one half-clock state, so a wait state is two cycles.
`timescale 1ns/1ps
`default_nettype none

// Widths and reset values come from the shared constants header
`include "bus_seq_params.svh"

// Contract
// RL1: Word cycles assert both strobes together
// RL2: Byte read strobe chosen by byte_select_bit
// RL3: Byte write strobe chosen by byte_select_bit
// RL4: Received byte moved to low operand position
// RL5: Unwaited cycle spans eight states S0..S7
// RL6: Read S0 drives codes, address, direction high
// RL7: Read asserts address and byte strobes S2
// RL8: Sample termination S4, else whole wait states; the code also samples in WAIT, so one clk can be inserted
// RL9: Slave data valid by S6, maybe S2; the code uses data_in as sampled at the edge leaving S4 or WAIT
// RL10: Read latches data, negates strobes entering S7
// RL11: Acknowledge with fault completes normally
// RL12: Fault-only read negates strobes in S9
// RL13: Slave drops fault after strobes negate
// RL14: Write S0 returns direction high
// RL15: Write asserts address strobe, direction low S2
// RL16: Write drives data bus from S3
// RL17: Write asserts byte strobes at S4
// RL18: Write ends S7: float data, direction high
// RL19: Fault-only write ends in S9 likewise
// RL20: Termination inputs pass two-stage synchronizer
// RL21: Report fault to core, discard data
module bus_seq #(
   parameter int ADDR_W = `BUS_ADDR_W,
   parameter int DATA_W = `BUS_DATA_W
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic req_valid,
   input wire bus_seq_pkg::bus_req_s req,
   output logic req_ready,
   output logic rsp_valid,
   output bus_seq_pkg::bus_rsp_s rsp,
   output logic [`BUS_FC_W-1:0] cycle_type_code,
   output logic [ADDR_W-1:0] addr,
   output logic read_not_write,
   output logic addr_strobe_n,
   output logic upper_byte_strobe_n,
   output logic lower_byte_strobe_n,
   output logic [DATA_W-1:0] data_out,
   output logic data_oe,
   input wire logic [DATA_W-1:0] data_in,
   input wire logic xfer_ack_n,
   input wire logic bus_fault_n
);
   initial begin
      if (ADDR_W != `BUS_ADDR_W || DATA_W != `BUS_DATA_W) begin
         $error("bus_seq: widths must match the package structs");
      end
   end

   bus_seq_pkg::bus_state_e state_r;
   bus_seq_pkg::bus_req_s cur_r;
   logic [1:0] ack_sync_r;
   logic [1:0] fault_sync_r;
   logic [DATA_W-1:0] din_sync1_r;
   logic [DATA_W-1:0] din_sync_r;
   logic ack_seen;
   logic fault_seen;
   logic sel_upper;
   logic sel_lower;
   logic [DATA_W-1:0] rd_word;

   // Termination and read data are asynchronous to clk
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ack_sync_r <= 2'h0;
         fault_sync_r <= 2'h0;
         din_sync1_r <= `BUS_DATA_RESET;
         din_sync_r <= `BUS_DATA_RESET;
      end else begin
         ack_sync_r <= {ack_sync_r[0], ~xfer_ack_n}; // see RL20
         fault_sync_r <= {fault_sync_r[0], ~bus_fault_n}; // see RL20
         din_sync1_r <= data_in;
         din_sync_r <= din_sync1_r;
      end
   end

   assign ack_seen = ack_sync_r[1];

   assign fault_seen = fault_sync_r[1];

   // Word cycles take both halves; bytes pick one by byte_select_bit
   assign sel_upper = ~cur_r.is_byte | ~cur_r.byte_addr[0]; // see RL1, RL2, RL3
   assign sel_lower = ~cur_r.is_byte | cur_r.byte_addr[0]; // see RL1, RL2, RL3

   always_comb begin
      rd_word = din_sync_r;
      if (cur_r.is_byte) begin
         // Odd bytes ride the low lane, even bytes the high lane
         rd_word = cur_r.byte_addr[0] ? {8'h00, din_sync_r[7:0]}
                                      : {8'h00, din_sync_r[15:8]}; // see RL4
      end
   end

   // Cycle timeline, one row per clk edge after the take edge T;
   // the state named is the one held until the next edge.
   //    T    S0   codes, address and direction high on the pins
   //    T+1  S1   no pin changes
   //    T+2  S2   address strobe low; byte strobes low on a read
   //    T+2  S2   direction low on a write
   //    T+3  S3   write data driven onto the bus
   //    T+4  S4   byte strobes low on a write
   //    T+5  S5   only if the synchronised acknowledge is up
   //    T+6  S6   read word settles in the synchroniser chain
   //    T+7  S7   all strobes high, answer to the core
   //    T+8  idle write data released, direction back high
   //
   // Wait states: S4 and WAIT alternate, one clk each, half a bus clock;
   // termination is acted on in both S4 and WAIT, so a wait can end after one clk.
   //
   // Fault without acknowledge: E5..E9 stand in for S5..S7 and the
   // strobes rise two cycles later than on the normal path; the core
   // gets the fault flag with zero data so no stale word leaks out.
   //
   // Limitation: termination passes two flops, so a slave that wants
   // no wait state must assert it by the edge that launches S2 plus
   // one; each edge later costs one WAIT clk, half a wait state.
   //
   // Trade-off: the synchroniser adds latency but keeps a termination
   // edge close to clk from splitting the decision between states.
   //
   // Read data goes through the same two flops, so the slave must hold
   // its word from S4 until the strobes rise; the word is taken at the
   // edge that ends S6.
   //
   // Sequencer; wait states alternate S4 and WAIT one clk each, exiting from either
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= bus_seq_pkg::ST_IDLE;
         cur_r <= '0;
      end else begin
         case (state_r)
            bus_seq_pkg::ST_IDLE: begin
               if (req_valid) begin
                  cur_r <= req;
                  state_r <= bus_seq_pkg::ST_S0;
               end
            end
            bus_seq_pkg::ST_S0: begin
               state_r <= bus_seq_pkg::ST_S1; // see RL5
            end
            bus_seq_pkg::ST_S1: begin
               state_r <= bus_seq_pkg::ST_S2;
            end
            bus_seq_pkg::ST_S2: begin
               state_r <= bus_seq_pkg::ST_S3;
            end
            bus_seq_pkg::ST_S3: begin
               state_r <= bus_seq_pkg::ST_S4;
            end
            bus_seq_pkg::ST_S4, bus_seq_pkg::ST_WAIT: begin
               // Acknowledge wins over fault; fault alone takes the long path
               if (ack_seen) begin
                  state_r <= bus_seq_pkg::ST_S5; // see RL8, RL11
               end else if (fault_seen) begin
                  state_r <= bus_seq_pkg::ST_E5; // see RL12, RL19
               end else if (state_r == bus_seq_pkg::ST_S4) begin
                  state_r <= bus_seq_pkg::ST_WAIT; // see RL8
               end else begin
                  state_r <= bus_seq_pkg::ST_S4;
               end
            end
            bus_seq_pkg::ST_S5: begin
               state_r <= bus_seq_pkg::ST_S6;
            end
            bus_seq_pkg::ST_S6: begin
               state_r <= bus_seq_pkg::ST_S7;
            end
            bus_seq_pkg::ST_S7: begin
               state_r <= bus_seq_pkg::ST_IDLE;
            end
            bus_seq_pkg::ST_E5: begin
               state_r <= bus_seq_pkg::ST_E6;
            end
            bus_seq_pkg::ST_E6: begin
               state_r <= bus_seq_pkg::ST_E7;
            end
            bus_seq_pkg::ST_E7: begin
               state_r <= bus_seq_pkg::ST_E8;
            end
            bus_seq_pkg::ST_E8: begin
               state_r <= bus_seq_pkg::ST_E9;
            end
            bus_seq_pkg::ST_E9: begin
               state_r <= bus_seq_pkg::ST_IDLE;
            end
            default: begin
               state_r <= bus_seq_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Core handshake: ready pulses for one cycle in idle while req_valid is low; a request is taken on req_valid alone
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         req_ready <= 1'b0;
      end else begin
         req_ready <= (state_r == bus_seq_pkg::ST_IDLE) && !req_valid && !req_ready;
      end
   end

   // Answer to the core; data is discarded on a fault-only end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rsp_valid <= 1'b0;
         rsp <= '0;
      end else begin
         rsp_valid <= 1'b0;
         if (state_r == bus_seq_pkg::ST_S6) begin
            rsp_valid <= 1'b1;
            rsp.fault <= 1'b0;
            rsp.rdata <= cur_r.write ? `BUS_DATA_RESET : rd_word; // see RL10, RL4
         end else if (state_r == bus_seq_pkg::ST_E8) begin
            rsp_valid <= 1'b1;
            rsp.fault <= 1'b1; // see RL21
            rsp.rdata <= `BUS_DATA_RESET; // see RL21
         end
      end
   end

   // Address, codes and direction
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cycle_type_code <= `BUS_FC_RESET;
         addr <= `BUS_ADDR_RESET;
         read_not_write <= 1'b1;
      end else begin
         if (state_r == bus_seq_pkg::ST_IDLE && req_valid) begin
            cycle_type_code <= req.type_code; // see RL6, RL14
            addr <= req.byte_addr[ADDR_W:1]; // see RL6, RL14
            read_not_write <= 1'b1; // see RL6, RL14
         end else if (state_r == bus_seq_pkg::ST_S1 && cur_r.write) begin
            read_not_write <= 1'b0; // see RL15
         end else if (state_r == bus_seq_pkg::ST_S7 || state_r == bus_seq_pkg::ST_E9) begin
            read_not_write <= 1'b1; // see RL18, RL19
         end
      end
   end

   // Strobes: outputs change one cycle after the state that schedules them
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         addr_strobe_n <= 1'b1;
         upper_byte_strobe_n <= 1'b1;
         lower_byte_strobe_n <= 1'b1;
      end else begin
         case (state_r)
            bus_seq_pkg::ST_S1: begin
               addr_strobe_n <= 1'b0; // see RL7, RL15
               if (!cur_r.write) begin
                  upper_byte_strobe_n <= ~sel_upper; // see RL7
                  lower_byte_strobe_n <= ~sel_lower; // see RL7
               end
            end
            bus_seq_pkg::ST_S3: begin
               if (cur_r.write) begin
                  upper_byte_strobe_n <= ~sel_upper; // see RL17
                  lower_byte_strobe_n <= ~sel_lower; // see RL17
               end
            end
            bus_seq_pkg::ST_S6, bus_seq_pkg::ST_E8: begin
               addr_strobe_n <= 1'b1; // see RL10, RL12, RL18, RL19
               upper_byte_strobe_n <= 1'b1;
               lower_byte_strobe_n <= 1'b1;
            end
            default: begin
               addr_strobe_n <= addr_strobe_n;
            end
         endcase
      end
   end

   // Write data drive: on from S3 through the end of S7 or S9
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         data_oe <= 1'b0;
         data_out <= `BUS_DATA_RESET;
      end else begin
         if (state_r == bus_seq_pkg::ST_S2 && cur_r.write) begin
            data_oe <= 1'b1; // see RL16
            data_out <= cur_r.wdata;
         end else if (state_r == bus_seq_pkg::ST_S7 || state_r == bus_seq_pkg::ST_E9) begin
            data_oe <= 1'b0; // see RL18, RL19
         end
      end
   end
endmodule
`default_nettype wire

// file: test/bus_seq_asserts.sv
// Port checker for the bus cycle sequencer.
// Assumes it is bound to bus_seq and sees one clock domain.
`timescale 1ns/1ps
`default_nettype none
module bus_seq_asserts #(
   parameter int ADDR_W = 23,
   parameter int DATA_W = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic req_valid,
   input wire bus_seq_pkg::bus_req_s req,
   input wire logic req_ready,
   input wire logic rsp_valid,
   input wire bus_seq_pkg::bus_rsp_s rsp,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic read_not_write,
   input wire logic addr_strobe_n,
   input wire logic upper_byte_strobe_n,
   input wire logic lower_byte_strobe_n,
   input wire logic [DATA_W-1:0] data_out,
   input wire logic data_oe,
   input wire logic xfer_ack_n,
   input wire logic bus_fault_n
);
   bus_seq_pkg::bus_req_s cap_r;
   logic idle_r;
   logic take;
   logic hi_n;
   assign take = idle_r && req_valid;
   assign hi_n = upper_byte_strobe_n && lower_byte_strobe_n;
   // Mirrors the idle state so the request can be kept for the whole cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) idle_r <= 1'b1;
      else if (take) idle_r <= 1'b0;
      else if (rsp_valid) idle_r <= 1'b1;
   end
   always_ff @(posedge clk) begin
      if (take) cap_r <= req;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_sel;
      !hi_n |-> (cap_r.is_byte ? (upper_byte_strobe_n == cap_r.byte_addr[0] &&
         lower_byte_strobe_n != cap_r.byte_addr[0]) : !upper_byte_strobe_n && !lower_byte_strobe_n);
   endproperty
   a_sel: assert property (p_sel) else $error("byte strobe choice wrong");
   property p_rd;
      take && !req.write |=> read_not_write && addr == cap_r.byte_addr[ADDR_W:1] &&
         addr_strobe_n ##1 addr_strobe_n ##1 !addr_strobe_n && !hi_n;
   endproperty
   a_rd: assert property (p_rd) else $error("read start wrong");
   property p_wr;
      take && req.write |=> read_not_write && addr_strobe_n ##1 read_not_write ##1
         !read_not_write && !addr_strobe_n && hi_n && !data_oe ##1 data_oe && hi_n &&
         (cap_r.is_byte || data_out == cap_r.wdata) ##1 !hi_n;
   endproperty
   a_wr: assert property (p_wr) else $error("write start wrong");
   property p_end;
      rsp_valid |-> $rose(addr_strobe_n);
   endproperty
   a_end: assert property (p_end) else $error("strobes not ending with reply");
   property p_wait;
      (!addr_strobe_n && xfer_ack_n && bus_fault_n) [*3] |=> !addr_strobe_n;
   endproperty
   a_wait: assert property (p_wait) else $error("cycle ended without reply");
   property p_pos;
      rsp_valid && !rsp.fault && cap_r.is_byte && !cap_r.write |-> rsp.rdata[15:8] == 8'h00;
   endproperty
   a_pos: assert property (p_pos) else $error("byte not in low lane");
   property p_flt;
      rsp_valid && rsp.fault |-> rsp.rdata == 16'h0000;
   endproperty
   a_flt: assert property (p_flt) else $error("fault data kept");
   property p_wend;
      $rose(addr_strobe_n) && !read_not_write |=> read_not_write && !data_oe;
   endproperty
   a_wend: assert property (p_wend) else $error("write tail wrong");
   property p_oe;
      data_oe |-> !read_not_write;
   endproperty
   a_oe: assert property (p_oe) else $error("data driven on read");
   property p_rdy;
      req_ready |-> $past(idle_r) && !$past(req_valid);
   endproperty
   a_rdy: assert property (p_rdy) else $error("ready outside idle");
   c_flt: cover property (rsp_valid && rsp.fault);
   c_wait: cover property ((!addr_strobe_n && xfer_ack_n) [*4]);
   c_byte: cover property (rsp_valid && cap_r.is_byte);
endmodule
bind bus_seq bus_seq_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (.clk(clk), .rst(rst),
   .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
   .rsp(rsp), .addr(addr),
   .read_not_write(read_not_write), .addr_strobe_n(addr_strobe_n), .data_oe(data_oe),
   .upper_byte_strobe_n(upper_byte_strobe_n), .lower_byte_strobe_n(lower_byte_strobe_n),
   .data_out(data_out), .xfer_ack_n(xfer_ack_n), .bus_fault_n(bus_fault_n));
`default_nettype wire

// file: test/bus_slave.sv
// Memory slave on the far side of the bus.
// Assumes the bench sets delay, reply kind and read word between cycles.
`timescale 1ns/1ps
`default_nettype none
module bus_slave (
   input wire logic clk,
   input wire logic rst,
   input wire logic addr_strobe_n,
   input wire logic upper_byte_strobe_n,
   input wire logic lower_byte_strobe_n,
   input wire logic read_not_write,
   input wire logic [15:0] data_out,
   input wire logic data_oe,
   input wire logic [3:0] wait_cycles,
   input wire logic [1:0] mode,
   input wire logic [15:0] rd_word,
   output logic [15:0] data_in,
   output logic xfer_ack_n,
   output logic bus_fault_n,
   output logic [15:0] wr_word,
   output logic [1:0] wr_seen
);
   logic as_d;
   logic [3:0] cnt;
   logic hit;
   assign hit = !addr_strobe_n && cnt >= wait_cycles;
   assign xfer_ack_n = !(hit && mode[0]);
   assign bus_fault_n = !(hit && mode[1]);
   // Off the bus the lines show the inverse, so stale data cannot pass
   assign data_in = (read_not_write && !(addr_strobe_n && as_d)) ? rd_word : ~rd_word;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         as_d <= 1'b1;
         cnt <= 4'h0;
         wr_seen <= 2'h0;
         wr_word <= 16'h0000;
      end else begin
         as_d <= addr_strobe_n;
         cnt <= addr_strobe_n ? 4'h0 : cnt + 4'h1;
         if (as_d && !addr_strobe_n) wr_seen <= 2'h0;
         else if (!read_not_write && data_oe) begin
            if (!upper_byte_strobe_n) wr_word[15:8] <= data_out[15:8];
            if (!lower_byte_strobe_n) wr_word[7:0] <= data_out[7:0];
            wr_seen <= wr_seen | {!upper_byte_strobe_n, !lower_byte_strobe_n};
         end
      end
   end
endmodule
`default_nettype wire

// file: test/async_bus_master_read_write_tb.sv
// Bench for the bus cycle sequencer against a memory slave model.
// Assumes the checker is bound in by its own file.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; \
   $display("BAD %s exp %h got %h", n, e, g); end end
module async_bus_master_read_write_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic req_valid = 1'b0;
   bus_seq_pkg::bus_req_s req = '0;
   bus_seq_pkg::bus_rsp_s rsp;
   logic rsp_valid, rnw, as_n, us_n, ls_n, oe, ack_n, flt_n;
   logic [2:0] code;
   logic [22:0] addr;
   logic [15:0] dout, din, wr_word;
   logic [1:0] wr_seen;
   logic [3:0] wait_cycles = 4'h0;
   logic [1:0] mode = 2'h1;
   logic [15:0] rd_word = 16'hA55A;
   int err_count = 0;
   int tests_run = 0;
   int lat;
   always #5 clk = ~clk;
   bus_seq dut (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req), .req_ready(),
      .rsp_valid(rsp_valid), .rsp(rsp), .cycle_type_code(code), .addr(addr),
      .read_not_write(rnw), .addr_strobe_n(as_n), .upper_byte_strobe_n(us_n),
      .lower_byte_strobe_n(ls_n), .data_out(dout), .data_oe(oe), .data_in(din),
      .xfer_ack_n(ack_n), .bus_fault_n(flt_n));
   bus_slave slv (.clk(clk), .rst(rst), .addr_strobe_n(as_n), .upper_byte_strobe_n(us_n),
      .lower_byte_strobe_n(ls_n), .read_not_write(rnw), .data_out(dout), .data_oe(oe),
      .wait_cycles(wait_cycles), .mode(mode), .rd_word(rd_word), .data_in(din),
      .xfer_ack_n(ack_n), .bus_fault_n(flt_n), .wr_word(wr_word), .wr_seen(wr_seen));
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // One idle cycle first, since a request raised in the reply cycle is not taken
   task automatic do_cycle(input logic w, input logic b, input logic [23:0] a,
      input logic [15:0] d);
      @(negedge clk);
      req <= '{w, b, 3'h5, a, d};
      req_valid <= 1'b1;
      lat = 0;
      do begin
         @(negedge clk);
         lat++;
         if (lat == 1) begin
            req_valid <= 1'b0;
            `CHK("addr", a[23:1], addr)
            `CHK("code", 3'h5, code)
         end
      end while (!rsp_valid && lat < 40);
      if (!rsp_valid) begin
         err_count++;
         give_verdict();
      end
   endtask
   task automatic t_read();
      do_cycle(1'b0, 1'b0, 24'h000100, 16'h0000);
      `CHK("lat", 8, lat)
      `CHK("word", 16'hA55A, rsp.rdata)
      do_cycle(1'b0, 1'b1, 24'h000100, 16'h0000);
      `CHK("even", 16'h00A5, rsp.rdata)
      do_cycle(1'b0, 1'b1, 24'h000101, 16'h0000);
      `CHK("odd", 16'h005A, rsp.rdata)
      $display("read test done");
   endtask
   task automatic t_write();
      do_cycle(1'b1, 1'b0, 24'h000200, 16'h1234);
      `CHK("wlat", 8, lat)
      `CHK("w0", 16'h1234, wr_word)
      do_cycle(1'b1, 1'b0, 24'h000202, 16'hBEEF);
      `CHK("w1", 16'hBEEF, wr_word)
      `CHK("wseen", 2'h3, wr_seen)
      do_cycle(1'b1, 1'b1, 24'h000200, 16'h7700);
      `CHK("beven", 2'h2, wr_seen)
      do_cycle(1'b1, 1'b1, 24'h000201, 16'h0077);
      `CHK("bodd", 2'h1, wr_seen)
      $display("write test done");
   endtask
   task automatic t_wait();
      wait_cycles <= 4'h2;
      do_cycle(1'b0, 1'b0, 24'h000300, 16'h0000);
      `CHK("wait", 10, lat)
      wait_cycles <= 4'h0;
      $display("wait test done");
   endtask
   task automatic t_fault();
      mode <= 2'h2;
      do_cycle(1'b0, 1'b0, 24'h000400, 16'h0000);
      `CHK("flat", 10, lat)
      `CHK("fault", 1'b1, rsp.fault)
      `CHK("fdata", 16'h0000, rsp.rdata)
      do_cycle(1'b1, 1'b0, 24'h000400, 16'h5555);
      `CHK("fwlat", 10, lat)
      mode <= 2'h3;
      do_cycle(1'b0, 1'b0, 24'h000400, 16'h0000);
      `CHK("both", 1'b0, rsp.fault)
      `CHK("blat", 8, lat)
      mode <= 2'h1;
      $display("fault test done");
   endtask
   initial begin
      repeat (2) @(posedge clk);
      @(negedge clk);
      rst <= 1'b0;
      t_read();
      t_write();
      t_wait();
      t_fault();
      give_verdict();
   end
endmodule
`default_nettype wire
